// ==== rtl/sph_ctrl.sv ====
/*
  handshake and flow-control gating for the primary (terminal end) and
  printer (communication end) serial ports.
  assumes a serializer outside that obeys tx_go and rx_en, and a receive
  buffer outside that reports occupancy and accepts push/pop strobes.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Data-terminal-ready is driven active on the primary port while the block is ready to move data.
// - With flow control chosen, data-terminal-ready drops once the receive buffer is half full.
// - No character is sent or taken on the primary port without data-set-ready active.
// - A primary character starts only while clear-to-send is active.
// - Primary characters are taken only while carrier detect is active.
// - In half duplex, request-to-send is raised before sending starts.
// - In full duplex, request-to-send is held active always.
// - An unconnected handshake input reads as active.
// - Primary serial data goes out on the transmit line and comes in on the receive line.
// - The printer port moves data only while the printer holds its terminal-ready active.
// - On the printer port, printer data arrives on transmit-data and block data leaves on receive-data.
module sph_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ready,
  input wire logic half_duplex,
  input wire logic dtr_flow,
  input wire sph_pkg::sph_line_t pri_dsr,
  input wire sph_pkg::sph_line_t pri_cts,
  input wire sph_pkg::sph_line_t pri_dcd,
  input wire sph_pkg::sph_line_t prn_dtr,
  input wire logic [`SPH_CNT_W-1:0] rx_fill,
  input wire logic pri_tx_req,
  input wire logic pri_tx_done,
  input wire logic pri_ser_out,
  input wire logic pri_rxd,
  input wire logic prn_ser_out,
  input wire logic prn_txd,
  output logic pri_txd,
  output logic pri_ser_in,
  output logic pri_rts,
  output logic pri_dtr,
  output logic pri_tx_go,
  output logic pri_rx_en,
  output logic prn_rxd,
  output logic prn_ser_in,
  output logic prn_tx_en,
  output logic prn_rx_en
);

  sph_pkg::sph_pri_hs_t hs;
  logic prn_ok;
  logic [3:0] line_act;
  sph_pkg::sph_line_t [3:0] line_raw;
  sph_pkg::sph_tx_state_t tx_state_q;
  logic [15:0] lead_q;
  logic buf_half_q;

  localparam logic [15:0] LEAD_CYC = 16'(`SPH_RTS_LEAD_CYC);

  // one folding stage per handshake line
  assign line_raw = {prn_dtr, pri_dcd, pri_cts, pri_dsr};

  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_line
      sph_line_in sph_line_in_inst (
        .mclk(mclk),
        .nrst(nrst),
        .line_in(line_raw[gi]),
        .active_q(line_act[gi])
      );
    end
  endgenerate

  // primary lines, then printer terminal-ready
  assign hs = {line_act[0], line_act[1], line_act[2]};
  assign prn_ok = line_act[3];

  // buffer half-full tracking
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      buf_half_q <= 1'b0;
    end else if (rx_fill >= `SPH_BUF_HALF) begin
      buf_half_q <= 1'b1;
    end else begin
      buf_half_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pri_dtr <= 1'b0;
    end else begin
      pri_dtr <= ready && !(dtr_flow && buf_half_q);
    end
  end

  // transmit sequencing with request-to-send lead in half duplex
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_state_q <= sph_pkg::SPH_TX_IDLE;
    end else begin
      case (tx_state_q)
        sph_pkg::SPH_TX_IDLE: begin
          if (pri_tx_req && ready) begin
            tx_state_q <= sph_pkg::SPH_TX_RTS_WAIT;
          end
        end
        // dropping the request aborts the wait
        sph_pkg::SPH_TX_RTS_WAIT: begin
          if (!pri_tx_req) begin
            tx_state_q <= sph_pkg::SPH_TX_IDLE;
          end else if (!half_duplex || lead_q <= 16'h0001) begin
            tx_state_q <= sph_pkg::SPH_TX_SEND;
          end
        end
        sph_pkg::SPH_TX_SEND: begin
          if (pri_tx_done || !pri_tx_req) begin
            tx_state_q <= sph_pkg::SPH_TX_IDLE;
          end
        end
        default: begin
          tx_state_q <= sph_pkg::SPH_TX_IDLE;
        end
      endcase
    end
  end

  // lead counter, preloaded while idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lead_q <= 16'h0000;
    end else if (tx_state_q == sph_pkg::SPH_TX_IDLE) begin
      lead_q <= LEAD_CYC;
    end else if (tx_state_q == sph_pkg::SPH_TX_RTS_WAIT &&
      lead_q > 16'h0001) begin
      lead_q <= lead_q - 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pri_rts <= 1'b0;
    end else if (!half_duplex) begin
      pri_rts <= 1'b1;
    end else begin
      pri_rts <= tx_state_q != sph_pkg::SPH_TX_IDLE;
    end
  end

  // serializer may start only with set-ready, clear-to-send and request-to-send all active
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pri_tx_go <= 1'b0;
    end else begin
      pri_tx_go <= tx_state_q == sph_pkg::SPH_TX_SEND && ready &&
        hs.dsr && hs.cts && pri_rts;
    end
  end

  // receive side needs set-ready and carrier
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pri_rx_en <= 1'b0;
    end else begin
      pri_rx_en <= ready && hs.dsr && hs.dcd;
    end
  end

  // data routing, idle line is mark
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pri_txd <= 1'b1;
    end else begin
      pri_txd <= pri_ser_out;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pri_ser_in <= 1'b1;
    end else begin
      pri_ser_in <= pri_rxd;
    end
  end

  // printer side held at mark while its terminal-ready is off
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prn_rxd <= 1'b1;
    end else begin
      prn_rxd <= prn_ok ? prn_ser_out : 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prn_ser_in <= 1'b1;
    end else begin
      prn_ser_in <= prn_ok ? prn_txd : 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prn_tx_en <= 1'b0;
    end else begin
      prn_tx_en <= ready && prn_ok;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prn_rx_en <= 1'b0;
    end else begin
      prn_rx_en <= ready && prn_ok;
    end
  end

endmodule : sph_ctrl

`default_nettype wire

// ==== rtl/sph_line_in.sv ====
/*
  one handshake input line: an absent line reads as active.
  assumes inputs synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module sph_line_in (
  input wire logic mclk,
  input wire logic nrst,
  input wire sph_pkg::sph_line_t line_in,
  output logic active_q
);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      active_q <= 1'b1;
    end else begin
      active_q <= !line_in.present || line_in.level;
    end
  end

endmodule : sph_line_in

`default_nettype wire

// ==== rtl/sph_params.svh ====
/*
  timing counts and fixed sizes for the serial port handshake control block.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef SPH_PARAMS_SVH
`define SPH_PARAMS_SVH

`define SPH_BUF_DEPTH 8'd64
`define SPH_BUF_HALF 8'd32
`define SPH_CNT_W 8
`define SPH_RTS_LEAD_NS 1000
`define SPH_CLK_NS 10
`define SPH_RTS_LEAD_CYC ((`SPH_RTS_LEAD_NS + `SPH_CLK_NS - 1) / `SPH_CLK_NS)

`endif

// ==== rtl/sph_pkg.sv ====
/*
  types shared by the handshake control block: line groups per port.
  assumes sph_params.svh is on the include path.
*/
`include "sph_params.svh"

package sph_pkg;

  // primary port incoming handshake, already folded to active-high
  typedef struct packed {
    logic dsr;
    logic cts;
    logic dcd;
  } sph_pri_hs_t;

  // raw line status: connected flag and level per handshake line
  typedef struct packed {
    logic present;
    logic level;
  } sph_line_t;

  typedef enum logic [1:0] {
    SPH_TX_IDLE,
    SPH_TX_RTS_WAIT,
    SPH_TX_SEND
  } sph_tx_state_t;

endpackage : sph_pkg

// ==== sim/sph_ctrl_bench.sv ====
/* bench for sph_ctrl; far side in sph_far_model */
`timescale 1ns/1ps
`default_nettype none
module sph_ctrl_bench;
  logic mclk = 1'b0, nrst = 1'b0, ready, half_duplex, dtr_flow;
  logic pri_tx_req, pri_tx_done, pri_ser_out, prn_ser_out;
  logic [7:0] rx_fill;
  sph_pkg::sph_line_t pri_dsr, pri_cts, pri_dcd, prn_dtr;
  wire pri_rxd, prn_txd, pri_txd, pri_ser_in, pri_rts, pri_dtr, pri_tx_go;
  wire pri_rx_en, prn_rxd, prn_ser_in, prn_tx_en, prn_rx_en;
  int err_count = 0, n_compared = 0;
  initial forever #5 mclk = ~mclk;
  sph_ctrl sph_ctrl_inst (.*);
  sph_far_model sph_far_model_inst (.*);
  task chk(input string n, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", n, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task done_pulse;
    @(posedge mclk) {pri_tx_done, pri_tx_req} <= 2'h2;
    @(posedge mclk) pri_tx_done <= 1'b0;
  endtask : done_pulse
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task t_gate;
    @(posedge mclk) {pri_dsr, pri_tx_req, prn_ser_out} <= 4'ha;
    cyc(4);
    chk("go", 0, pri_tx_go);
    chk("rx", 0, pri_rx_en);
    @(posedge mclk) {pri_dsr, pri_dcd, prn_dtr} <= 6'h3a;
    cyc(4);
    chk("rx", 0, pri_rx_en);
    chk("go", 1, pri_tx_go);
    chk("pen", 0, prn_tx_en);
    chk("prxd", 1, prn_rxd);
    chk("pren", 0, prn_rx_en);
    chk("psin", 1, prn_ser_in);
    @(posedge mclk) pri_cts <= 2'h2;
    cyc(4);
    chk("go", 0, pri_tx_go);
    done_pulse();
  endtask : t_gate
  task t_flow;
    @(posedge mclk) {dtr_flow, rx_fill} <= 9'h120;
    cyc(4);
    chk("dtr", 0, pri_dtr);
    @(posedge mclk) rx_fill <= 8'h1f;
    cyc(4);
    chk("dtr", 1, pri_dtr);
  endtask : t_flow
  task t_half;
    @(posedge mclk) {half_duplex, dtr_flow, pri_cts, pri_dcd} <= 6'h20;
    cyc(4);
    chk("rts", 0, pri_rts);
    @(posedge mclk) pri_tx_req <= 1'b1;
    for (int i = 0; i < 200 && pri_tx_go !== 1'b1; i++) cyc(1);
    if (pri_tx_go !== 1'b1) begin
      err_count++;
      $display("MISMATCH go_timeout exp 1 got %b", pri_tx_go);
      wrap_up();
    end
    chk("rts", 1, pri_rts);
    done_pulse();
    cyc(3);
    chk("rts", 0, pri_rts);
  endtask : t_half
  initial begin
    {ready, half_duplex, dtr_flow, pri_tx_req, pri_tx_done} = '0;
    {pri_ser_out, prn_ser_out, rx_fill} = 10'h300;
    {pri_dsr, pri_cts, pri_dcd, prn_dtr} = 8'h00;
    repeat (16) @(posedge mclk);
    {nrst, ready} <= 2'h3;
    cyc(4);
    chk("rts", 1, pri_rts);
    chk("dtr", 1, pri_dtr);
    chk("rx", 1, pri_rx_en);
    t_gate();
    t_flow();
    t_half();
    @(posedge mclk) {prn_dtr, pri_ser_out, prn_ser_out} <= 4'h0;
    cyc(3);
    chk("txd", 0, pri_txd);
    chk("sin", !pri_rxd, pri_ser_in);
    chk("prxd", 0, prn_rxd);
    chk("psin", !prn_txd, prn_ser_in);
    chk("pren", 1, prn_rx_en);
    wrap_up();
  end
endmodule : sph_ctrl_bench
bind sph_ctrl sph_ctrl_props sph_ctrl_props_inst (.*);
`default_nettype wire

// ==== sim/sph_ctrl_props.sv ====
/* handshake checker on sph_ctrl ports; bound from the bench */
`timescale 1ns/1ps
`default_nettype none
module sph_ctrl_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ready,
  input wire logic half_duplex,
  input wire logic dtr_flow,
  input wire sph_pkg::sph_line_t pri_dsr,
  input wire sph_pkg::sph_line_t pri_cts,
  input wire sph_pkg::sph_line_t pri_dcd,
  input wire sph_pkg::sph_line_t prn_dtr,
  input wire logic [7:0] rx_fill,
  input wire logic pri_tx_req,
  input wire logic pri_tx_go,
  input wire logic pri_rx_en,
  input wire logic pri_rts,
  input wire logic pri_dtr,
  input wire logic prn_tx_en
);
  wire ds = !pri_dsr.present || pri_dsr.level;
  wire cs = !pri_cts.present || pri_cts.level;
  wire cd = !pri_dcd.present || pri_dcd.level;
  wire pd = !prn_dtr.present || prn_dtr.level;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_hd;
    $rose(pri_tx_req) && half_duplex && ready;
  endsequence
  property p_ds; !ds [*3] |-> !pri_tx_go && !pri_rx_en; endproperty
  a_ds: assert property (p_ds) else $error("dsr gate");
  property p_cs; !cs [*3] |-> !pri_tx_go; endproperty
  a_cs: assert property (p_cs) else $error("cts gate");
  property p_cd; !cd [*3] |-> !pri_rx_en; endproperty
  a_cd: assert property (p_cd) else $error("dcd gate");
  property p_hd; s_hd |-> ##[1:3] pri_rts; endproperty
  a_hd: assert property (p_hd) else $error("rts late");
  property p_fd; !half_duplex [*3] |-> pri_rts; endproperty
  a_fd: assert property (p_fd) else $error("rts low");
  property p_fl;
    (dtr_flow && rx_fill >= 8'h20) [*3] |-> !pri_dtr;
  endproperty
  a_fl: assert property (p_fl) else $error("dtr held");
  property p_bk;
    (ready && dtr_flow && rx_fill < 8'h20) [*3] |-> pri_dtr;
  endproperty
  a_bk: assert property (p_bk) else $error("dtr not back");
  property p_pr; !pd [*3] |-> !prn_tx_en; endproperty
  a_pr: assert property (p_pr) else $error("printer gate");
endmodule : sph_ctrl_props
`default_nettype wire

// ==== sim/sph_far_model.sv ====
/* host and printer line model; printer toggles data each cycle, host too unless flow-controlled DTR is low (then mark) */
`timescale 1ns/1ps
`default_nettype none
module sph_far_model (
  input wire logic mclk,
  input wire logic pri_dtr,
  input wire logic dtr_flow,
  output logic pri_rxd,
  output logic prn_txd
);
  initial {pri_rxd, prn_txd} = 2'h3;
  always @(posedge mclk) begin
    pri_rxd <= (pri_dtr || !dtr_flow) ? !pri_rxd : 1'b1;
    prn_txd <= !prn_txd;
  end
endmodule : sph_far_model
`default_nettype wire
